// ==== hdl/lsc_delay_timer.sv ====
// Purpose: Millisecond down-counter for minimum pulse spacing
// Assumes: tick_i is a one-cycle pulse once per millisecond
// Notes:   One extra count covers the partial first tick, so a delay is never short
module lsc_delay_timer #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         tick_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_i,
  output logic              done_o
);
  logic [W:0] count;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= (load_i == '0) ? '0 : ({1'b0, load_i} + {{W{1'b0}}, 1'b1});
    end else if (tick_i && count != '0) begin
      count <= count - {{W{1'b0}}, 1'b1};
    end
  end

  assign done_o = (count == '0);
endmodule

// ==== hdl/lsc_load_ctrl.sv ====
// Purpose: Load shedding, dummy load and load add/subtract control with AXI4-Lite registers
// Assumes: power_i is produced by metering logic on sys_clk_i
// Notes:   Limits compare unsigned power; delays count whole milliseconds
//
// Chosen here: register access over AXI4-Lite and the address map.
`include "lsc_params.svh"

module lsc_load_ctrl #(
  parameter int NUM_DOUT    = 8,
  parameter int TICK_CYCLES = `LSC_TICK_CYCLES
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [15:0]          power_i,
  output logic                      shed_o,
  output logic                      dummy_o,
  output logic                      load_add_o,
  output logic                      load_sub_o,
  output logic [NUM_DOUT-1:0]       dig_out_o,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  localparam int TW = $clog2(TICK_CYCLES);

  lsc_pkg::lsc_word_t high_lim;
  lsc_pkg::lsc_word_t low_lim;
  lsc_pkg::lsc_word_t same_dly;
  lsc_pkg::lsc_word_t opp_dly;
  lsc_pkg::lsc_word_t route_cfg;
  lsc_pkg::lsc_dir_t  last_dir;
  logic [TW-1:0]      div;
  logic               tick;
  logic               above;
  logic               below;
  logic               next_shed;
  logic               add_same_done;
  logic               sub_same_done;
  logic               opp_done;
  logic               opp_block_add;
  logic               opp_block_sub;
  logic               sub_go;
  logic               add_go;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               aw_hs;
  logic               w_hs;
  logic               ar_hs;
  logic               do_wr;
  logic               wr_hit;
  logic               next_rvalid;
  logic [31:0]        rd_word;
  logic               rd_hit;

  function automatic lsc_pkg::lsc_word_t merge16(input lsc_pkg::lsc_word_t old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
    lsc_pkg::lsc_word_t r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div  <= '0;
      tick <= 1'b0;
    end else if (div == TW'(TICK_CYCLES - 1)) begin
      div  <= '0;
      tick <= 1'b1;
    end else begin
      div  <= div + {{(TW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shedding and dummy load
  // ----------------------------------------------------------------
  assign above = (power_i > high_lim);
  assign below = (power_i < low_lim);

  // Upper limit wins if software sets the limits the wrong way round
  always_comb begin
    next_shed = shed_o;
    if (above) begin
      next_shed = 1'b1;
    end else if (below) begin
      next_shed = 1'b0;
    end
  end

  // No enable term: free-running from reset release
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shed_o  <= 1'b0;
      dummy_o <= 1'b1;
    end else begin
      shed_o  <= next_shed;
      dummy_o <= ~next_shed;
    end
  end

  lsc_out_route #(
    .N (NUM_DOUT)
  ) u_route (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .level_i   (shed_o),
    .inv_i     (route_cfg[`LSC_ROUTE_INV]),
    .sel_i     (route_cfg[7:0]),
    .dig_out_o (dig_out_o)
  );

  // ----------------------------------------------------------------
  // Load add / subtract pacing
  // ----------------------------------------------------------------
  assign opp_block_add = (last_dir == lsc_pkg::LSC_DIR_SUB) && !opp_done;
  assign opp_block_sub = (last_dir == lsc_pkg::LSC_DIR_ADD) && !opp_done;
  // Conditions are re-evaluated every cycle, so a deferred pulse needs the limit still crossed
  assign sub_go = !load_sub_o && above && sub_same_done && !opp_block_sub;
  assign add_go = !load_add_o && below && add_same_done && !opp_block_add && !sub_go;

  lsc_delay_timer #(.W(16)) u_add_same (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .start_i   (add_go),
    .load_i    (same_dly),
    .done_o    (add_same_done)
  );

  lsc_delay_timer #(.W(16)) u_sub_same (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .start_i   (sub_go),
    .load_i    (same_dly),
    .done_o    (sub_same_done)
  );

  lsc_delay_timer #(.W(16)) u_opp (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .start_i   (add_go | sub_go),
    .load_i    (opp_dly),
    .done_o    (opp_done)
  );

  // Outputs stay high until the external system moves power back past the limit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_add_o <= 1'b0;
    end else if (add_go) begin
      load_add_o <= 1'b1;
    end else if (!below) begin
      load_add_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_sub_o <= 1'b0;
    end else if (sub_go) begin
      load_sub_o <= 1'b1;
    end else if (!above) begin
      load_sub_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_dir <= lsc_pkg::LSC_DIR_NONE;
    end else begin
      case (1'b1)
        sub_go:  last_dir <= lsc_pkg::LSC_DIR_SUB;
        add_go:  last_dir <= lsc_pkg::LSC_DIR_ADD;
        default: last_dir <= last_dir;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign do_wr = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_hs) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      aw_held       <= (aw_held | aw_hs) & !do_wr;
      w_held        <= (w_held | w_hs) & !do_wr;
      s_axi_awready <= !((aw_held | aw_hs) & !do_wr);
      s_axi_wready  <= !((w_held | w_hs) & !do_wr);
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (wr_addr == `LSC_ADDR_HIGH) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `LSC_ADDR_LOW) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `LSC_ADDR_SAME) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `LSC_ADDR_OPP) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `LSC_ADDR_ROUTE) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_lim  <= `LSC_RST_HIGH;
      low_lim   <= `LSC_RST_LOW;
      same_dly  <= `LSC_RST_SAME;
      opp_dly   <= `LSC_RST_OPP;
      route_cfg <= `LSC_RST_ROUTE;
    end else if (do_wr) begin
      if (wr_addr == `LSC_ADDR_HIGH) begin
        high_lim <= merge16(high_lim, wr_data, wr_strb);
      end else if (wr_addr == `LSC_ADDR_LOW) begin
        low_lim <= merge16(low_lim, wr_data, wr_strb);
      end else if (wr_addr == `LSC_ADDR_SAME) begin
        same_dly <= merge16(same_dly, wr_data, wr_strb);
      end else if (wr_addr == `LSC_ADDR_OPP) begin
        opp_dly <= merge16(opp_dly, wr_data, wr_strb);
      end else if (wr_addr == `LSC_ADDR_ROUTE) begin
        route_cfg <= merge16(route_cfg, wr_data, wr_strb);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign ar_hs       = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = ar_hs | (s_axi_rvalid & !s_axi_rready);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == `LSC_ADDR_HIGH) begin
      rd_word[15:0] = high_lim;
    end else if (s_axi_araddr == `LSC_ADDR_LOW) begin
      rd_word[15:0] = low_lim;
    end else if (s_axi_araddr == `LSC_ADDR_SAME) begin
      rd_word[15:0] = same_dly;
    end else if (s_axi_araddr == `LSC_ADDR_OPP) begin
      rd_word[15:0] = opp_dly;
    end else if (s_axi_araddr == `LSC_ADDR_ROUTE) begin
      rd_word[15:0] = route_cfg;
    end else if (s_axi_araddr == `LSC_ADDR_STATUS) begin
      rd_word[`LSC_ST_SHED]     = shed_o;
      rd_word[`LSC_ST_DUMMY]    = dummy_o;
      rd_word[`LSC_ST_ADD]      = load_add_o;
      rd_word[`LSC_ST_SUB]      = load_sub_o;
      rd_word[`LSC_ST_ADD_WAIT] = below && !load_add_o;
      rd_word[`LSC_ST_SUB_WAIT] = above && !load_sub_o;
    end else if (s_axi_araddr == `LSC_ADDR_POWER) begin
      rd_word[15:0] = power_i;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LSC_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_shed_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i) above |=> shed_o;
  endproperty
  a_shed_set: assert property (p_shed_set) else $error("shed not set above upper limit");

  property p_shed_clr;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (below && !above) |=> !shed_o;
  endproperty
  a_shed_clr: assert property (p_shed_clr) else $error("shed not cleared below lower limit");

  property p_shed_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (!below && !above) |=> $stable(shed_o);
  endproperty
  a_shed_hold: assert property (p_shed_hold) else $error("shed changed between limits");

  property p_dummy_inv;
    @(posedge sys_clk_i) disable iff (!rst_n_i) dummy_o != shed_o;
  endproperty
  a_dummy_inv: assert property (p_dummy_inv) else $error("dummy not inverse of shed");

  property p_add_drop;
    @(posedge sys_clk_i) disable iff (!rst_n_i) !below |=> !load_add_o;
  endproperty
  a_add_drop: assert property (p_add_drop) else $error("add held above lower limit");

  property p_sub_drop;
    @(posedge sys_clk_i) disable iff (!rst_n_i) !above |=> !load_sub_o;
  endproperty
  a_sub_drop: assert property (p_sub_drop) else $error("subtract held below upper limit");

  property p_add_space;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(load_add_o) |-> $past(add_same_done) ##1 (same_dly == '0 || !add_same_done);
  endproperty
  a_add_space: assert property (p_add_space) else $error("add pulse spacing broken");

  property p_sub_space;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(load_sub_o) |-> $past(sub_same_done) ##1 (same_dly == '0 || !sub_same_done);
  endproperty
  a_sub_space: assert property (p_sub_space) else $error("subtract pulse spacing broken");

  property p_opp_defer;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (below && !load_add_o && opp_block_add) |=> !load_add_o;
  endproperty
  a_opp_defer: assert property (p_opp_defer) else $error("add not deferred by opposite delay");

  property p_recheck;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(load_add_o) || $rose(load_sub_o) |-> $past(below) || $past(above);
  endproperty
  a_recheck: assert property (p_recheck) else $error("pulse without limit crossed");

  c_add_pulse: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(load_add_o));
  c_sub_pulse: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(load_sub_o));
  c_deferred:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
                               (below && opp_block_add) ##[1:1000] $rose(load_add_o));
  c_shed_rise: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(shed_o));
endmodule

// ==== hdl/lsc_out_route.sv ====
// Purpose: Steers the shedding level onto one general digital output
// Assumes: Select and level come from the same clock domain
// Notes:   An index beyond the outputs drives none of them
module lsc_out_route #(
  parameter int N = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         level_i,
  input  wire logic         inv_i,
  input  wire logic [7:0]   sel_i,
  output logic      [N-1:0] dig_out_o
);
  for (genvar i = 0; i < N; i++) begin : g_out
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dig_out_o[i] <= 1'b0;
      end else begin
        dig_out_o[i] <= (sel_i == 8'(i)) ? (level_i ^ inv_i) : 1'b0;
      end
    end
  end
endmodule

// ==== hdl/lsc_params.svh ====
// Purpose: Constants of the load shedding and load add/subtract controller
// Assumes: 20 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   Delays are programmed in milliseconds
//
// Operation
// - Shedding logic runs always out of reset; no enable exists.
// - Shedding level can be routed to any one general digital output.
// - Power above upper limit sets the shedding output.
// - Power below lower limit clears the shedding output.
// - Dummy-load output is the exact inverse of the shedding output.
// - Increase-load output is high while power is below lower limit.
// - Decrease-load output is high while power is above upper limit.
// - New increase pulse waits the same-direction delay since the previous one.
// - Same-direction delay also separates two decrease pulses.
// - Opposite pulse waits the opposite-direction delay; early requests are deferred.
// - At delay expiry the limit is re-checked before the deferred pulse.
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSC_CLK_MHZ      32'h14
`define LSC_TICK_US      32'h3e8
`define LSC_TICK_CYCLES  (`LSC_TICK_US * `LSC_CLK_MHZ)

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define LSC_ADDR_HIGH    8'h00
`define LSC_ADDR_LOW     8'h04
`define LSC_ADDR_SAME    8'h08
`define LSC_ADDR_OPP     8'h0c
`define LSC_ADDR_ROUTE   8'h10
`define LSC_ADDR_STATUS  8'h14
`define LSC_ADDR_POWER   8'h18

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define LSC_RST_HIGH     16'h0c00
`define LSC_RST_LOW      16'h0400
`define LSC_RST_SAME     16'h000a
`define LSC_RST_OPP      16'h0014
`define LSC_RST_ROUTE    16'h0000
`define LSC_ROUTE_INV    8
`define LSC_ST_SHED      0
`define LSC_ST_DUMMY     1
`define LSC_ST_ADD       2
`define LSC_ST_SUB       3
`define LSC_ST_ADD_WAIT  4
`define LSC_ST_SUB_WAIT  5
`define LSC_RESP_OKAY    2'h0
`define LSC_RESP_SLVERR  2'h2

`endif

// ==== hdl/lsc_pkg.sv ====
// Purpose: Types of the load shedding and load add/subtract controller
// Assumes: Constants come from lsc_params.svh
// Notes:   Types only
package lsc_pkg;
  typedef logic [15:0] lsc_word_t;
  typedef enum logic [1:0] {
    LSC_DIR_NONE,
    LSC_DIR_ADD,
    LSC_DIR_SUB
  } lsc_dir_t;
endpackage

// ==== verif/lsc_load_sys.sv ====
// Purpose: Model of the external multi-step load system
// Assumes: Power follows set_i while auto_i is low
// Notes:   Step size and step rate are arbitrary
module lsc_load_sys #(
  parameter logic [15:0] STEP = 16'h0030
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        auto_i,
  input  wire logic [15:0] set_i,
  input  wire logic        add_i,
  input  wire logic        sub_i,
  output logic      [15:0] power_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  // Steps every fourth cycle only: a slow load system
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div     <= 2'h0;
      power_o <= set_i;
    end else if (!auto_i) begin
      power_o <= set_i;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3 && add_i) begin
        power_o <= power_o + STEP;
      end else if (div == 2'h3 && sub_i) begin
        power_o <= power_o - STEP;
      end
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench of the load controller
// Assumes: 1 ms tick shortened to 10 cycles
// Notes:   Delays set to 3 ms and 6 ms
`include "lsc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        auto    = 1'b0;
  logic [15:0] set_pw  = 16'h0600;
  logic [15:0] power;
  logic        shed, dummy, add, sub, add_q, sub_q;
  logic [7:0]  dig;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          err_total, checks_done, cyc, add_n, sub_n, add_gap, sub_gap, opp_gap, n;
  int          add_last = -1000;
  int          sub_last = -1000;
  logic [31:0] rv [5] = '{32'(`LSC_RST_HIGH), 32'(`LSC_RST_LOW), 32'(`LSC_RST_SAME),
                          32'(`LSC_RST_OPP), 32'(`LSC_RST_ROUTE)};
  logic [31:0] cv [5] = '{32'h0800, 32'h0200, 32'h0003, 32'h0006, 32'h0003};

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  lsc_load_sys u_lsc_load_sys (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .auto_i(auto),
    .set_i(set_pw), .add_i(add), .sub_i(sub), .power_o(power));

  lsc_load_ctrl #(.NUM_DOUT(8), .TICK_CYCLES(10)) u_lsc_load_ctrl (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .power_i(power), .shed_o(shed),
    .dummy_o(dummy), .load_add_o(add), .load_sub_o(sub), .dig_out_o(dig),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ----------------------------------------------------------------
  // Pulse spacing monitor
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    cyc   <= cyc + 1;
    add_q <= add;
    sub_q <= sub;
    if (add && !add_q) begin
      add_n    <= add_n + 1;
      add_gap  <= cyc - add_last;
      opp_gap  <= cyc - sub_last;
      add_last <= cyc;
    end
    if (sub && !sub_q) begin
      sub_n    <= sub_n + 1;
      sub_gap  <= cyc - sub_last;
      sub_last <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic pw(input logic [15:0] p);
    set_pw <= p;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic await_pulse();
    int t;
    t = add_n + sub_n;
    for (int i = 0; i < 150 && add_n + sub_n == t; i++) @(posedge sys_clk);
    // A missing pulse is a failure, not a silent fall-through
    if (add_n + sub_n == t) begin
      err_total++;
      $display("Error %0t: no pulse within limit", $time);
    end
    @(posedge sys_clk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axr(8'(4 * i));
      chk(d, rv[i]);
    end
    axr(8'h1c);
    chk(d, 32'h0);
    chk(32'(r), 32'h2);
    chk(32'({shed, dummy}), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      axw(8'(4 * i), cv[i]);
      chk(32'(r), 32'h0);
      axr(8'(4 * i));
      chk(d, cv[i]);
    end
    axw(8'h20, 32'h1);
    chk(32'(r), 32'h2);
    $display("test config done");
    pw(16'h0900);
    chk(32'({shed, dummy, sub, add}), 32'ha);
    chk(32'(dig), 32'h08);
    axr(8'h14);
    chk(d, 32'h09);
    axr(8'h18);
    chk(d, 32'h0900);
    pw(16'h0500);
    chk(32'({shed, sub}), 32'h2);
    pw(16'h0100);
    chk(32'({shed, dummy, add}), 32'h2);
    axr(8'h14);
    chk(d, 32'h12);
    await_pulse();
    chk(32'(add), 32'h1);
    chk(32'(opp_gap inside {[60:72]}), 32'h1);
    axr(8'h14);
    chk(d, 32'h06);
    pw(16'h0300);
    chk(32'(add), 32'h0);
    pw(16'h0100);
    chk(32'(add), 32'h0);
    await_pulse();
    chk(32'(add_gap inside {[30:42]}), 32'h1);
    $display("test add done");
    pw(16'h0900);
    chk(32'(sub), 32'h0);
    axr(8'h14);
    chk(d, 32'h21);
    n = sub_n;
    pw(16'h0500);
    repeat (80) @(posedge sys_clk);
    chk(sub_n, n);
    pw(16'h0900);
    chk(32'(sub), 32'h1);
    pw(16'h0500);
    pw(16'h0900);
    await_pulse();
    chk(32'(sub_gap inside {[30:42]}), 32'h1);
    $display("test sub done");
    for (int i = 0; i < 10; i++) begin
      axw(8'h10, 32'(i) | (i[0] ? 32'h100 : 32'h0));
      repeat (2) @(posedge sys_clk);
      chk(32'(dig), (i < 8 && !i[0]) ? 32'h1 << i : 32'h0);
    end
    $display("test route done");
    pw(16'h0100);
    auto <= 1'b1;
    repeat (200) @(posedge sys_clk);
    chk(32'(power), 32'h220);
    chk(32'(add), 32'h0);
    $display("test loop done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
